// ### inc/dms_pkg.sv
// Package for the DLL mode switch sequencer: constants, commands, states, carriers
package dms_pkg;

  // APB register offsets
  localparam logic [7:0] DMS_CTRL_OFF = 8'h00;
  localparam logic [7:0] DMS_STAT_OFF = 8'h04;
  localparam logic [7:0] DMS_TIME0_OFF = 8'h08;
  localparam logic [7:0] DMS_TIME1_OFF = 8'h0c;
  localparam logic [7:0] DMS_TIME2_OFF = 8'h10;
  localparam logic [7:0] DMS_MR0_OFF = 8'h14;
  localparam logic [7:0] DMS_MR1_OFF = 8'h18;
  localparam logic [7:0] DMS_MR2_OFF = 8'h1c;
  localparam logic [7:0] DMS_MR3_OFF = 8'h20;

  // Control register fields
  localparam int DMS_CTRL_GO_BIT = 0;
  localparam int DMS_CTRL_DIR_BIT = 1;
  localparam int DMS_CTRL_ODTEN_BIT = 2;
  localparam int DMS_CTRL_ZQ_BIT = 3;
  localparam int DMS_CTRL_FREQOK_BIT = 4;

  // Status register fields
  localparam int DMS_STAT_BUSY_BIT = 0;
  localparam int DMS_STAT_DONE_BIT = 1;
  localparam int DMS_STAT_FREQ_BIT = 2;
  localparam int DMS_STAT_LOCK_BIT = 3;
  localparam int DMS_STAT_STATE_LSB = 8;

  // Mode register bit positions
  localparam int DMS_MR1_DLL_BIT = 0;
  localparam int DMS_MR0_DLLRST_BIT = 8;

  // Nanosecond timing converted by rounding up to whole cycles
  localparam int DMS_CLK_PS = 8000;
  localparam int DMS_TCKSRE_NS = 10;
  localparam int DMS_TCKSRX_NS = 10;
  localparam int DMS_TXS_NS = 170;
  localparam int DMS_MOD_NCK = 12;
  localparam int DMS_MRD_NCK = 4;
  localparam int DMS_DLLK_NCK = 512;
  localparam int DMS_ZQOPER_NCK = 256;

  // Cycle counts, rounded up
  localparam logic [15:0] DMS_TCKSRE_CYC = 16'((DMS_TCKSRE_NS * 1000 + DMS_CLK_PS - 1) / DMS_CLK_PS);
  localparam logic [15:0] DMS_TCKSRX_CYC = 16'((DMS_TCKSRX_NS * 1000 + DMS_CLK_PS - 1) / DMS_CLK_PS);
  localparam logic [15:0] DMS_TXS_CYC = 16'((DMS_TXS_NS * 1000 + DMS_CLK_PS - 1) / DMS_CLK_PS);

  // Widths and mode register indices
  localparam int DMS_ADDR_W = 14;
  localparam logic [2:0] DMS_MR0_IDX = 3'h0;
  localparam logic [2:0] DMS_MR1_IDX = 3'h1;
  localparam logic [2:0] DMS_MR2_IDX = 3'h2;
  localparam logic [2:0] DMS_MR3_IDX = 3'h3;

  // Command encodings: cs_n, ras_n, cas_n, we_n
  localparam logic [3:0] DMS_CMD_NOP = 4'h7;
  localparam logic [3:0] DMS_CMD_MRS = 4'h0;
  localparam logic [3:0] DMS_CMD_SRE = 4'h1;
  localparam logic [3:0] DMS_CMD_ZQ = 4'h6;
  localparam logic [13:0] DMS_ZQCL_ADDR = 14'h0400;

  // Sequencer states
  typedef enum logic [4:0] {
    DMS_IDLE = 5'h00,
    DMS_OFF_MR1 = 5'h01,
    DMS_OFF_MOD = 5'h03,
    DMS_SRE = 5'h02,
    DMS_CKSRE = 5'h06,
    DMS_FREQ = 5'h07,
    DMS_CKSRX = 5'h05,
    DMS_SRX = 5'h04,
    DMS_TXS = 5'h0c,
    DMS_MR1_ON = 5'h0d,
    DMS_MR0_RST = 5'h0f,
    DMS_MRS_UPD = 5'h0e,
    DMS_ZQ = 5'h0a,
    DMS_WAIT_END = 5'h0b,
    DMS_DONE = 5'h09
  } dms_state_t;

  // Pin group toward the memory
  typedef struct packed {
    logic cke;
    logic odt;
    logic [3:0] cmd;
    logic [2:0] ba;
    logic [DMS_ADDR_W-1:0] addr;
  } dms_pins_t;

  // APB request carrier
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } dms_apb_req_t;

endpackage : dms_pkg

// ### logic/dms_mr_store.sv
// Small memory of the mode register images with registered read data
`timescale 1ns/10ps
`default_nettype none
module dms_mr_store (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [1:0] wr_idx_in,
  input wire logic [dms_pkg::DMS_ADDR_W-1:0] wr_data_in,
  // Read port
  input wire logic [1:0] rd_idx_in,
  output logic [dms_pkg::DMS_ADDR_W-1:0] rd_data_out
);
  import dms_pkg::*;

  logic [DMS_ADDR_W-1:0] mem_r [4];

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < 4; i++) begin
        mem_r[i] <= '0;
      end
      rd_data_out <= '0;
    end else begin
      if (wr_en_in) begin
        mem_r[wr_idx_in] <= wr_data_in;
      end
      rd_data_out <= mem_r[rd_idx_in];
    end
  end
endmodule : dms_mr_store
`default_nettype wire

// ### logic/dms_dll_switch.sv
// DLL on/off switch sequencer driving the memory command pins, run over APB
// Summary of operation
// - Start only from idle with banks precharged, timings met and termination off.
// - Enter self refresh and wait the clock-after-entry time before the clock changes.
// - Hold a stable clock for the clock-before-exit time before self refresh exit.
// - Keep CKE high from self refresh exit until DLL lock time after DLL reset.
// - If termination was enabled at entry, keep ODT low until DLL lock time after reset.
// - If termination was disabled at entry, ODT may be at either level.
// - After the exit delay write mode register 1 bit A0 as 0 to enable the DLL.
// - A mode-register-set delay later write mode register 0 bit A8 as 1 to reset the DLL.
// - A further mode-register-set delay later program the new frequency settings.
// - Long ZQ calibration may follow once the update delay from the last write passed.
// - No DLL-dependent command before the DLL lock time after reset has passed.
// - After a long ZQ calibration also wait the ZQ operation time.
// - For on-to-off write mode register 1 bit A0 as 1 before self refresh entry.
// - After on-to-off exit reprogram the mode registers for DLL-off before other commands.
// - Cycle delays are counted in clock edges; mode register writes are 4 cycles apart.
// - Nanosecond timings convert to cycles rounding up.
// - The clock may change only in self refresh or precharge power-down.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module dms_dll_switch (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // APB slave
  input wire dms_pkg::dms_apb_req_t apb_in,
  output logic pready_out,
  output logic pslverr_out,
  output logic [31:0] prdata_out,
  // Memory pins
  output dms_pkg::dms_pins_t mem_out,
  // Clock source control
  output logic freq_change_ok_out,
  output logic dll_locked_out
);
  import dms_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register bank
  logic go_r, dir_r, odten_r, zq_r, freqok_r, done_r;
  logic dir_nxt;
  dms_state_t st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] dllk_r, dllk_nxt;
  logic [1:0] upd_r, upd_nxt;
  dms_pins_t pins_r, pins_nxt;
  logic [DMS_ADDR_W-1:0] mr_rd;
  logic [1:0] mr_rd_idx;
  logic wr_acc, rd_acc;
  wire wr_ctrl = wr_acc && apb_in.paddr == DMS_CTRL_OFF;
  wire [1:0] wr_mr_idx = 2'((apb_in.paddr - DMS_MR0_OFF) >> 2);
  wire wr_mr = wr_acc && apb_in.paddr >= DMS_MR0_OFF && apb_in.paddr <= DMS_MR3_OFF;
  wire addr_ok = apb_in.paddr <= DMS_MR3_OFF && apb_in.paddr[1:0] == 2'h0;
  wire busy = st_r != DMS_IDLE && st_r != DMS_DONE;
  logic mr_wait_r;
  wire rd_mr = apb_in.psel && apb_in.penable && !apb_in.pwrite && addr_ok &&
               apb_in.paddr >= DMS_MR0_OFF;
  // Image the sequencer needs one cycle ahead, else the one software addresses
  wire [1:0] store_rd_idx = (st_r == DMS_MRS_UPD) ? upd_r :
                            (st_r == DMS_OFF_MR1) ? DMS_MR1_IDX[1:0] :
                            (st_r == DMS_TXS) ? (dir_r ? DMS_MR0_IDX[1:0] : DMS_MR1_IDX[1:0]) :
                            (st_r == DMS_MR1_ON || st_r == DMS_MR0_RST) ? DMS_MR0_IDX[1:0] :
                            mr_rd_idx;

  assign wr_acc = apb_in.psel && apb_in.penable && apb_in.pwrite && addr_ok;
  assign rd_acc = apb_in.psel && !apb_in.penable && !apb_in.pwrite;
  // Mode image reads hold one wait state for the registered store output
  assign pready_out = !(rd_mr && !mr_wait_r);
  assign pslverr_out = apb_in.psel && apb_in.penable && !addr_ok;
  assign mem_out = pins_r;
  assign freq_change_ok_out = st_r == DMS_FREQ;
  assign dll_locked_out = dllk_r == '0;

  // Read setup cycle selects the image one cycle early
  assign mr_rd_idx = 2'((apb_in.paddr - DMS_MR0_OFF) >> 2);

  function automatic logic [15:0] dms_dec(input logic [15:0] v);
    dms_dec = (v == '0) ? '0 : 16'(v - 16'h0001);
  endfunction : dms_dec

  function automatic logic [DMS_ADDR_W-1:0] dms_setbit(input logic [DMS_ADDR_W-1:0] v,
                                                      input int pos, input logic b);
    logic [DMS_ADDR_W-1:0] r;
    r = v;
    r[pos] = b;
    dms_setbit = r;
  endfunction : dms_setbit

  dms_mr_store u_store (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .wr_en_in(wr_mr),
    .wr_idx_in(wr_mr_idx),
    .wr_data_in(apb_in.pwdata[DMS_ADDR_W-1:0]),
    .rd_idx_in(store_rd_idx),
    .rd_data_out(mr_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      go_r <= 1'b0;
      dir_r <= 1'b0;
      odten_r <= 1'b0;
      zq_r <= 1'b0;
      freqok_r <= 1'b0;
    end else begin
      go_r <= wr_ctrl && !busy && apb_in.pwdata[DMS_CTRL_GO_BIT];
      if (wr_ctrl && !busy) begin
        dir_r <= apb_in.pwdata[DMS_CTRL_DIR_BIT];
        odten_r <= apb_in.pwdata[DMS_CTRL_ODTEN_BIT];
        zq_r <= apb_in.pwdata[DMS_CTRL_ZQ_BIT];
      end
      if (wr_ctrl) begin
        freqok_r <= apb_in.pwdata[DMS_CTRL_FREQOK_BIT];
      end else if (st_r != DMS_FREQ) begin
        freqok_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read wait state
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mr_wait_r <= 1'b0;
    end else begin
      mr_wait_r <= rd_mr && !mr_wait_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prdata_out <= '0;
    end else if (rd_acc) begin
      prdata_out <= '0;
      if (apb_in.paddr == DMS_CTRL_OFF) begin
        prdata_out[DMS_CTRL_DIR_BIT] <= dir_r;
        prdata_out[DMS_CTRL_ODTEN_BIT] <= odten_r;
        prdata_out[DMS_CTRL_ZQ_BIT] <= zq_r;
      end else if (apb_in.paddr == DMS_STAT_OFF) begin
        prdata_out[DMS_STAT_BUSY_BIT] <= busy;
        prdata_out[DMS_STAT_DONE_BIT] <= done_r;
        prdata_out[DMS_STAT_FREQ_BIT] <= st_r == DMS_FREQ;
        prdata_out[DMS_STAT_LOCK_BIT] <= dllk_r == '0;
        prdata_out[DMS_STAT_STATE_LSB +: 5] <= st_r;
      end else if (apb_in.paddr == DMS_TIME0_OFF) begin
        prdata_out <= {DMS_TCKSRX_CYC, DMS_TCKSRE_CYC};
      end else if (apb_in.paddr == DMS_TIME1_OFF) begin
        prdata_out <= {16'(DMS_MOD_NCK), DMS_TXS_CYC};
      end else if (apb_in.paddr == DMS_TIME2_OFF) begin
        prdata_out <= {16'(DMS_ZQOPER_NCK), 16'(DMS_DLLK_NCK)};
      end
    end else if (apb_in.psel && apb_in.penable && !apb_in.pwrite &&
                 apb_in.paddr >= DMS_MR0_OFF && apb_in.paddr <= DMS_MR3_OFF) begin
      prdata_out <= 32'(mr_rd);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = dms_dec(cnt_r);
    dllk_nxt = dms_dec(dllk_r);
    upd_nxt = upd_r;
    dir_nxt = dir_r;
    pins_nxt = pins_r;
    pins_nxt.cmd = DMS_CMD_NOP;
    case (st_r)
      DMS_IDLE, DMS_DONE: begin
        if (go_r) begin
          pins_nxt.odt = 1'b0;
          cnt_nxt = 16'h0001;
          st_nxt = dir_r ? DMS_OFF_MR1 : DMS_SRE;
        end
      end
      DMS_OFF_MR1: begin
        if (cnt_r == '0) begin
          pins_nxt.cmd = DMS_CMD_MRS;
          pins_nxt.ba = DMS_MR1_IDX;
          pins_nxt.addr = dms_setbit(mr_rd, DMS_MR1_DLL_BIT, 1'b1);
          cnt_nxt = 16'(DMS_MOD_NCK - 1);
          st_nxt = DMS_OFF_MOD;
        end
      end
      DMS_OFF_MOD: begin
        if (cnt_r == '0) begin
          st_nxt = DMS_SRE;
        end
      end
      DMS_SRE: begin
        pins_nxt.cmd = DMS_CMD_SRE;
        pins_nxt.cke = 1'b0;
        cnt_nxt = DMS_TCKSRE_CYC - 16'h0001;
        st_nxt = DMS_CKSRE;
      end
      DMS_CKSRE: begin
        if (cnt_r == '0) begin
          st_nxt = DMS_FREQ;
        end
      end
      DMS_FREQ: begin
        if (freqok_r) begin
          cnt_nxt = DMS_TCKSRX_CYC - 16'h0001;
          st_nxt = DMS_CKSRX;
        end
      end
      DMS_CKSRX: begin
        if (cnt_r == '0) begin
          st_nxt = DMS_SRX;
        end
      end
      DMS_SRX: begin
        pins_nxt.cke = 1'b1;
        pins_nxt.odt = 1'b0;
        cnt_nxt = DMS_TXS_CYC - 16'h0001;
        st_nxt = DMS_TXS;
      end
      DMS_TXS: begin
        if (cnt_r == '0) begin
          upd_nxt = '0;
          st_nxt = dir_r ? DMS_MRS_UPD : DMS_MR1_ON;
        end
      end
      DMS_MR1_ON: begin
        pins_nxt.cmd = DMS_CMD_MRS;
        pins_nxt.ba = DMS_MR1_IDX;
        pins_nxt.addr = dms_setbit(mr_rd, DMS_MR1_DLL_BIT, 1'b0);
        cnt_nxt = 16'(DMS_MRD_NCK - 1);
        st_nxt = DMS_MR0_RST;
      end
      DMS_MR0_RST: begin
        if (cnt_r == '0) begin
          pins_nxt.cmd = DMS_CMD_MRS;
          pins_nxt.ba = DMS_MR0_IDX;
          pins_nxt.addr = dms_setbit(mr_rd, DMS_MR0_DLLRST_BIT, 1'b1);
          dllk_nxt = 16'(DMS_DLLK_NCK);
          cnt_nxt = 16'(DMS_MRD_NCK - 1);
          upd_nxt = '0;
          st_nxt = DMS_MRS_UPD;
        end
      end
      DMS_MRS_UPD: begin
        if (cnt_r == '0) begin
          pins_nxt.cmd = DMS_CMD_MRS;
          pins_nxt.ba = {1'b0, upd_r};
          pins_nxt.addr = mr_rd;
          if (upd_r == DMS_MR1_IDX[1:0]) begin
            pins_nxt.addr = dms_setbit(mr_rd, DMS_MR1_DLL_BIT, dir_r);
          end
          cnt_nxt = 16'(DMS_MRD_NCK - 1);
          upd_nxt = 2'(upd_r + 2'h1);
          if (upd_r == 2'h3) begin
            cnt_nxt = 16'(DMS_MOD_NCK - 1);
            st_nxt = zq_r ? DMS_ZQ : DMS_WAIT_END;
          end
        end
      end
      DMS_ZQ: begin
        if (cnt_r == '0) begin
          pins_nxt.cmd = DMS_CMD_ZQ;
          pins_nxt.addr = DMS_ZQCL_ADDR;
          cnt_nxt = 16'(DMS_ZQOPER_NCK - 1);
          st_nxt = DMS_WAIT_END;
        end
      end
      DMS_WAIT_END: begin
        if (cnt_r == '0 && dllk_r == '0) begin
          st_nxt = DMS_DONE;
        end
      end
      default: begin
        st_nxt = DMS_IDLE;
      end
    endcase
    if (odten_r && st_r != DMS_IDLE && st_r != DMS_DONE) begin
      pins_nxt.odt = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State and pin registers
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= DMS_IDLE;
      cnt_r <= '0;
      dllk_r <= '0;
      upd_r <= '0;
      done_r <= 1'b0;
      pins_r <= '{cke: 1'b1, odt: 1'b0, cmd: DMS_CMD_NOP, ba: '0, addr: '0};
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      dllk_r <= dllk_nxt;
      upd_r <= upd_nxt;
      pins_r <= pins_nxt;
      done_r <= st_nxt == DMS_DONE;
    end
  end
endmodule : dms_dll_switch
`default_nettype wire

// ### sim/dms_dll_switch_sva.sv
// Port checker of the DLL switch sequencer
`timescale 1ns/10ps
`default_nettype none
module dms_dll_switch_sva (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // APB side
  input wire dms_pkg::dms_apb_req_t apb_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [31:0] prdata_out,
  // Memory and clock source side
  input wire dms_pkg::dms_pins_t mem_out,
  input wire logic freq_change_ok_out,
  input wire logic dll_locked_out
);
  import dms_pkg::*;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////////////////////////
  // Cycles since the last mode write and the last DLL reset
  logic [7:0] gap_r;
  logic [7:0] gap_nxt;
  logic [10:0] lk_r;
  logic [10:0] lk_nxt;
  wire is_mrs = mem_out.cmd == DMS_CMD_MRS;
  wire is_rst = is_mrs && mem_out.ba == DMS_MR0_IDX && mem_out.addr[DMS_MR0_DLLRST_BIT];
  assign gap_nxt = is_mrs ? 8'h01 : gap_r + {7'h00, gap_r != 8'hff};
  assign lk_nxt = is_rst ? 11'h001 : lk_r + {10'h000, lk_r != 11'h7ff};
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gap_r <= 8'hff;
      lk_r <= 11'h7ff;
    end else begin
      gap_r <= gap_nxt;
      lk_r <= lk_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  chk_sre_cke: assert property (
    $fell(mem_out.cke) |-> mem_out.cmd == DMS_CMD_SRE) else $error("cke fell without entry");
  chk_cksre_wait: assert property (
    $fell(mem_out.cke) |-> !freq_change_ok_out [*2]) else $error("clock change too early");
  chk_freq_in_sr: assert property (
    freq_change_ok_out |-> !mem_out.cke) else $error("clock change outside self refresh");
  chk_odt_low: assert property (
    !mem_out.odt) else $error("odt driven high");
  chk_cksrx_wait: assert property (
    $rose(mem_out.cke) |-> !$past(freq_change_ok_out) && !$past(freq_change_ok_out, 2))
    else $error("exit too soon after clock change");
  chk_cke_hold: assert property (
    $rose(mem_out.cke) |=> mem_out.cke [*8]) else $error("cke dropped after exit");
  chk_mrs_gap: assert property (
    is_mrs |-> gap_r >= 8'd4) else $error("mode writes too close");
  chk_zq_gap: assert property (
    mem_out.cmd == DMS_CMD_ZQ |-> gap_r >= 8'd12) else $error("calibration too soon");
  chk_dll_order: assert property (
    is_rst |-> $past(is_mrs && mem_out.ba == DMS_MR1_IDX && !mem_out.addr[0], 4))
    else $error("dll reset not after enable");
  chk_lock_time: assert property (
    $rose(dll_locked_out) |-> lk_r >= 11'd512) else $error("lock reported early");
endmodule : dms_dll_switch_sva
bind dms_dll_switch dms_dll_switch_sva dms_dll_switch_sva_i (.ref_clk_in(ref_clk_in),
  .rst_b_in(rst_b_in), .apb_in(apb_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .prdata_out(prdata_out), .mem_out(mem_out), .freq_change_ok_out(freq_change_ok_out),
  .dll_locked_out(dll_locked_out));
`default_nettype wire

// ### sim/dms_dram_model.sv
// Behavioural memory device watching the command pins
`timescale 1ns/10ps
`default_nettype none
module dms_dram_model (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Memory pins
  input wire dms_pkg::dms_pins_t mem_in,
  // Device state
  output logic dll_on_out,
  output logic self_refresh_state_out,
  output logic [7:0] rst_cnt_out,
  output logic [15:0] lock_cyc_out,
  output logic [15:0] zq_cyc_out
);
  import dms_pkg::*;
  wire mrs = mem_in.cke && mem_in.cmd == DMS_CMD_MRS;
  wire mr1 = mrs && mem_in.ba == DMS_MR1_IDX;
  wire mr0 = mrs && mem_in.ba == DMS_MR0_IDX && mem_in.addr[DMS_MR0_DLLRST_BIT] && dll_on_out;
  wire zq = mem_in.cke && mem_in.cmd == DMS_CMD_ZQ;
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dll_on_out <= 1'b1;
      self_refresh_state_out <= 1'b0;
      rst_cnt_out <= 8'h00;
      lock_cyc_out <= 16'h0000;
      zq_cyc_out <= 16'h0000;
    end else begin
      if (!mem_in.cke && mem_in.cmd == DMS_CMD_SRE)
        self_refresh_state_out <= 1'b1;
      else if (mem_in.cke)
        self_refresh_state_out <= 1'b0;
      if (mr1)
        dll_on_out <= !mem_in.addr[DMS_MR1_DLL_BIT];
      if (mr0)
        rst_cnt_out <= rst_cnt_out + 8'h01;
      if (mr0)
        lock_cyc_out <= 16'h0001;
      else if (lock_cyc_out != 16'h0000 && lock_cyc_out != 16'hffff)
        lock_cyc_out <= lock_cyc_out + 16'h0001;
      if (zq)
        zq_cyc_out <= 16'h0001;
      else if (zq_cyc_out != 16'h0000 && zq_cyc_out != 16'hffff)
        zq_cyc_out <= zq_cyc_out + 16'h0001;
    end
  end
endmodule : dms_dram_model
`default_nettype wire

// ### sim/tb_dms_dll_switch.sv
// Testbench of the DLL switch sequencer with a memory model
`timescale 1ns/10ps
`default_nettype none
module tb_dms_dll_switch;
  import dms_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  dms_apb_req_t apb = '0;
  logic rdy, err, fok, lkd, dll_on, sr_on, e;
  logic [31:0] rd, q;
  dms_pins_t pins;
  logic [7:0] rst_cnt;
  logic [15:0] lock_cyc, zq_cyc;
  logic [31:0] mr [4] = '{32'h0a30, 32'h0044, 32'h0018, 32'h0000};
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  dms_dll_switch dms_dll_switch_i (.ref_clk_in(clk), .rst_b_in(rst_b), .apb_in(apb),
    .pready_out(rdy), .pslverr_out(err), .prdata_out(rd), .mem_out(pins),
    .freq_change_ok_out(fok), .dll_locked_out(lkd));
  dms_dram_model dms_dram_model_i (.ref_clk_in(clk), .rst_b_in(rst_b), .mem_in(pins),
    .dll_on_out(dll_on), .self_refresh_state_out(sr_on), .rst_cnt_out(rst_cnt),
    .lock_cyc_out(lock_cyc), .zq_cyc_out(zq_cyc));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb.penable <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
    end
    q = rd;
    e = err;
    apb <= '0;
    @(posedge clk);
  endtask : xfer
  task automatic wait_stat(input int b);
    int n;
    n = 0;
    q = '0;
    while (q[b] !== 1'b1 && n < 2000) begin
      xfer(DMS_STAT_OFF, 1'b0, '0);
      n++;
    end
  endtask : wait_stat
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      print_verdict;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk("cke at reset", 32'h1, {31'h0, pins.cke});
    chk("cmd at reset", 32'h7, {28'h0, pins.cmd});
    xfer(DMS_STAT_OFF, 1'b0, '0);
    chk("busy at reset", 32'h0, {31'h0, q[DMS_STAT_BUSY_BIT]});
    xfer(8'h24, 1'b0, '0);
    chk("unmapped error", 32'h1, {31'h0, e});
    xfer(8'h02, 1'b1, 32'h0);
    chk("unaligned error", 32'h1, {31'h0, e});
    foreach (mr[i]) xfer(DMS_MR0_OFF + 8'(4 * i), 1'b1, mr[i]);
    foreach (mr[i]) begin
      xfer(DMS_MR0_OFF + 8'(4 * i), 1'b0, '0);
      xfer(DMS_MR0_OFF + 8'(4 * i), 1'b0, '0);
      chk("mode image", mr[i], {18'h0, q[13:0]});
    end
    // On to off
    xfer(DMS_CTRL_OFF, 1'b1, 32'h3);
    wait_stat(DMS_STAT_FREQ_BIT);
    chk("dll off before entry", 32'h0, {31'h0, dll_on});
    chk("in self refresh", 32'h1, {31'h0, sr_on});
    chk("freq window", 32'h1, {31'h0, fok});
    xfer(DMS_CTRL_OFF, 1'b1, 32'h10);
    wait_stat(DMS_STAT_DONE_BIT);
    chk("dll stays off", 32'h0, {31'h0, dll_on});
    chk("left self refresh", 32'h0, {31'h0, sr_on});
    // Off to on with termination and calibration, direction change refused while busy
    xfer(DMS_CTRL_OFF, 1'b1, 32'hd);
    wait_stat(DMS_STAT_FREQ_BIT);
    chk("in self refresh", 32'h1, {31'h0, sr_on});
    xfer(DMS_CTRL_OFF, 1'b1, 32'h13);
    wait_stat(DMS_STAT_DONE_BIT);
    chk("dll on", 32'h1, {31'h0, dll_on});
    chk("dll resets", 32'h1, {24'h0, rst_cnt});
    chk("locked port", 32'h1, {31'h0, lkd});
    chk("locked status", 32'h1, {31'h0, q[DMS_STAT_LOCK_BIT]});
    chk("lock wait", 32'h1, {31'h0, lock_cyc >= 16'(DMS_DLLK_NCK)});
    chk("calibration wait", 32'h1, {31'h0, zq_cyc >= 16'(DMS_ZQOPER_NCK)});
    xfer(DMS_CTRL_OFF, 1'b0, '0);
    chk("control kept while busy", 32'hc, q);
    xfer(DMS_TIME1_OFF, 1'b0, '0);
    chk("exit delay cycles", 32'h000c0016, q);
    print_verdict;
  end
endmodule : tb_dms_dll_switch
`default_nettype wire
